// ### core/servo_sup_pkg.sv
// constants, types and register map of the servo supervisor
package servo_sup_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_MAX = 20000;
  localparam int SPEED_W = 16;
  localparam int POS_W = 32;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OVR_WIDTH = 8'h04;
  localparam logic [7:0] A_FUNC_ONE = 8'h08;
  localparam logic [7:0] A_DLY_GAIN = 8'h0C;
  localparam logic [7:0] A_TRQ_OFS = 8'h10;
  localparam logic [7:0] A_DECEL_TC = 8'h14;
  localparam logic [7:0] A_GATE_DLY = 8'h18;
  localparam logic [7:0] A_DROP_TIME = 8'h1C;
  localparam logic [7:0] A_MEC_GAIN = 8'h20;
  localparam logic [7:0] A_PLOOP_GAIN = 8'h24;
  localparam logic [7:0] A_FUNC_FIVE = 8'h28;
  localparam logic [7:0] A_RADIUS = 8'h2C;
  localparam logic [7:0] A_RAPID = 8'h30;
  localparam logic [7:0] A_STATUS = 8'h34;
  localparam logic [7:0] A_MEC_OUT = 8'h38;
  localparam int CTRL_CLOSED = 0;
  localparam int CTRL_DECEL = 1;
  localparam int CTRL_DROP = 2;
  localparam int CTRL_ALM_RST = 3;
  localparam int CTRL_PULLUP = 4;
  localparam int UNIT_UM_BIT = 13;
  localparam int OVR_ALARM_CODE = 43;
  localparam logic signed [15:0] OVR_DISABLE = -16'sd1;
  localparam logic [31:0] OVR_DEFAULT_UM = 32'd2000;
  localparam logic [31:0] UM_PER_MM = 32'd1000;
  localparam logic signed [31:0] OVR_MAX = 32'sd32767;
  localparam logic signed [31:0] DLY_MAX = 32'sd32767;
  localparam logic signed [31:0] TRQ_MAX = 32'sd100;
  localparam logic signed [31:0] MEC_MAX = 32'sd30000;
  localparam logic signed [31:0] TIME_MAX = 32'sd20000;
  localparam logic [23:0] MEC_SCALE = 24'd16200000;
  localparam int DIV_STEPS = 48;
  localparam logic [1:0] VC_OFF = 2'b00;
  localparam logic [1:0] VC_TYPE1 = 2'b01;
  localparam logic [1:0] VC_TYPE2 = 2'b10;
  localparam logic [1:0] VC_BAD = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DECEL = 2'b01,
    ST_OFF = 2'b10
  } stop_state_e;
  typedef struct packed {
    logic sync_db;
    logic db_alarm;
    logic drive_alarm;
    logic power_down;
    logic estop;
  } stop_pins_s;
endpackage : servo_sup_pkg

// ### core/servo_estop_overrun_supervisor.sv
// per-axis overrun, compensation and emergency stop supervisor
// Behaviour
// RQ1: closed loop: motor vs scale difference above width raises alarm 43, stops axis
// RQ2: width of -1 disables overrun detection
// RQ3: width of zero uses a 2 mm detection width
// RQ4: width clamps -1..32767, mm or um per unit-select bit D
// RQ5: selector 00 off, 01 type 1, 10 type 2, 11 prohibited
// RQ6: type 2 reduces lead compensation only once position droop is zero
// RQ7: delay gain 0..32767 applied per selected changeover method
// RQ8: torque offset -100..100, sign sets pull-up direction, zero disables
// RQ9: external stop, controller power-down or own alarm start an emergency stop
// RQ10: decel stop ramps with READY on, then READY off and dynamic brake
// RQ11: dynamic brake alarm skips the ramp and brakes at once
// RQ12: ramp slope is rapid rate over time constant from any speed
// RQ13: zero time constant stops by a position loop step
// RQ14: synchronous axes use equal negative constants and share dynamic brake stops
// RQ15: controller keeps the time constant within recommended rapid limits
// RQ16: READY forced off after max gate-off delay, 0..20000 ms
// RQ17: drop prevention stretches gate-off to at least the drop time
// RQ18: controller sets gate-off delay to largest decel constant plus 100 ms
// RQ19: machine end gain -30000..30000 in 0.1 percent, zero unused
// RQ20: compensation equals F squared times gain over radius, loop gain, 16200000
// RQ21: decel constant -20000..20000 ms, negative marks synchronous axes
// RQ22: drop prevention time holds READY until the brake engages
// RQ23: gate-off timer counts ms from first stop cycle, forces READY off
// RQ24: overrun alarm stays latched until controller alarm reset
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module servo_estop_overrun_supervisor #(
  parameter int MS_CYCLES = servo_sup_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // stop pins, asynchronous
  input wire servo_sup_pkg::stop_pins_s stop_pins,
  // feedback and command, same clock
  input wire logic signed [31:0] motor_pos,
  input wire logic signed [31:0] scale_pos,
  input wire logic signed [31:0] pos_droop,
  input wire logic [15:0] speed_in,
  // drive outputs
  output logic ready_ff,
  output logic dyn_brake_ff,
  output logic axis_stop_ff,
  output logic overrun_alarm_ff,
  output logic sync_db_out_ff,
  output logic [15:0] speed_out_ff,
  output logic lead_reduce_ff,
  output logic [15:0] delay_gain_out_ff,
  output logic pullup_ff,
  output logic pullup_dir_ff,
  output logic signed [31:0] mec_amount_ff
);
  function automatic logic [15:0] sat(input logic signed [31:0] v, input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = (v < lo) ? lo : ((v > hi) ? hi : v);
    return r[15:0];
  endfunction : sat

  // registers
  logic [4:0] ctrl_ff;
  logic signed [15:0] overrun_width_ff;
  logic [15:0] servo_function_one_ff, delay_comp_gain_ff, function_select_five_ff;
  logic signed [15:0] torque_offset_ff, estop_decel_time_const_ff, machine_end_gain_ff;
  logic [15:0] max_gate_off_delay_ff, drop_prevent_time_ff, position_loop_gain_ff;
  logic [15:0] radius_ff, rapid_ff;
  logic alm_rst_ff, bad_sel_ff;
  logic aw_ff, w_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  servo_sup_pkg::stop_state_e state_ff;

  // axi write path, unmapped writes are dropped but still answered okay
  wire do_wr = aw_ff && w_ff && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= servo_sup_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= servo_sup_pkg::RESP_OKAY;
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes with range clamping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= 5'h00;
      overrun_width_ff <= 16'h0000;
      servo_function_one_ff <= 16'h0000;
      delay_comp_gain_ff <= 16'h0000;
      torque_offset_ff <= 16'h0000;
      estop_decel_time_const_ff <= 16'h0000;
      max_gate_off_delay_ff <= 16'h0000;
      drop_prevent_time_ff <= 16'h0000;
      machine_end_gain_ff <= 16'h0000;
      position_loop_gain_ff <= 16'h0001;
      function_select_five_ff <= 16'h0000;
      radius_ff <= 16'h0001;
      rapid_ff <= 16'h0000;
      alm_rst_ff <= 1'b0;
    end else begin
      alm_rst_ff <= do_wr && awaddr_ff == servo_sup_pkg::A_CTRL && wdata_ff[servo_sup_pkg::CTRL_ALM_RST];
      if (do_wr) begin
        unique case (awaddr_ff)
          servo_sup_pkg::A_CTRL: ctrl_ff <= wdata_ff[4:0] & 5'h17;
          servo_sup_pkg::A_OVR_WIDTH: overrun_width_ff <= sat(wdata_ff, -32'sd1, servo_sup_pkg::OVR_MAX); // RQ4
          servo_sup_pkg::A_FUNC_ONE: servo_function_one_ff <= wdata_ff[15:0];
          servo_sup_pkg::A_DLY_GAIN: delay_comp_gain_ff <= sat(wdata_ff, 32'sd0, servo_sup_pkg::DLY_MAX); // RQ7
          servo_sup_pkg::A_TRQ_OFS: torque_offset_ff <= sat(wdata_ff, -servo_sup_pkg::TRQ_MAX,
                                                            servo_sup_pkg::TRQ_MAX); // RQ8
          servo_sup_pkg::A_DECEL_TC: estop_decel_time_const_ff <= sat(wdata_ff, -servo_sup_pkg::TIME_MAX,
                                                                      servo_sup_pkg::TIME_MAX); // RQ21
          servo_sup_pkg::A_GATE_DLY: max_gate_off_delay_ff <= sat(wdata_ff, 32'sd0, servo_sup_pkg::TIME_MAX); // RQ16
          servo_sup_pkg::A_DROP_TIME: drop_prevent_time_ff <= sat(wdata_ff, 32'sd0, servo_sup_pkg::TIME_MAX);
          servo_sup_pkg::A_MEC_GAIN: machine_end_gain_ff <= sat(wdata_ff, -servo_sup_pkg::MEC_MAX,
                                                                servo_sup_pkg::MEC_MAX); // RQ19
          servo_sup_pkg::A_PLOOP_GAIN: position_loop_gain_ff <= wdata_ff[15:0];
          servo_sup_pkg::A_FUNC_FIVE: function_select_five_ff <= wdata_ff[15:0];
          servo_sup_pkg::A_RADIUS: radius_ff <= wdata_ff[15:0];
          servo_sup_pkg::A_RAPID: rapid_ff <= wdata_ff[15:0];
          default: ;
        endcase
      end
    end
  end

  // axi read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= servo_sup_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= servo_sup_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          servo_sup_pkg::A_CTRL: s_axi_rdata <= {27'h0, ctrl_ff};
          servo_sup_pkg::A_OVR_WIDTH: s_axi_rdata <= {{16{overrun_width_ff[15]}}, overrun_width_ff};
          servo_sup_pkg::A_FUNC_ONE: s_axi_rdata <= {16'h0000, servo_function_one_ff};
          servo_sup_pkg::A_DLY_GAIN: s_axi_rdata <= {16'h0000, delay_comp_gain_ff};
          servo_sup_pkg::A_TRQ_OFS: s_axi_rdata <= {{16{torque_offset_ff[15]}}, torque_offset_ff};
          servo_sup_pkg::A_DECEL_TC: s_axi_rdata <= {{16{estop_decel_time_const_ff[15]}}, estop_decel_time_const_ff};
          servo_sup_pkg::A_GATE_DLY: s_axi_rdata <= {16'h0000, max_gate_off_delay_ff};
          servo_sup_pkg::A_DROP_TIME: s_axi_rdata <= {16'h0000, drop_prevent_time_ff};
          servo_sup_pkg::A_MEC_GAIN: s_axi_rdata <= {{16{machine_end_gain_ff[15]}}, machine_end_gain_ff};
          servo_sup_pkg::A_PLOOP_GAIN: s_axi_rdata <= {16'h0000, position_loop_gain_ff};
          servo_sup_pkg::A_FUNC_FIVE: s_axi_rdata <= {16'h0000, function_select_five_ff};
          servo_sup_pkg::A_RADIUS: s_axi_rdata <= {16'h0000, radius_ff};
          servo_sup_pkg::A_RAPID: s_axi_rdata <= {16'h0000, rapid_ff};
          servo_sup_pkg::A_STATUS: s_axi_rdata <= {16'h0000, 8'(servo_sup_pkg::OVR_ALARM_CODE), 1'b0, bad_sel_ff,
                                                   state_ff, sync_db_out_ff, dyn_brake_ff, ready_ff,
                                                   overrun_alarm_ff};
          servo_sup_pkg::A_MEC_OUT: s_axi_rdata <= mec_amount_ff;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= servo_sup_pkg::RESP_DECERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // three-stage pin synchronisers, accepted when stages two and three agree
  logic [4:0] s1_ff, s2_ff, s3_ff, pin_ff;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_ff[g] <= 1'b0;
          s2_ff[g] <= 1'b0;
          s3_ff[g] <= 1'b0;
          pin_ff[g] <= 1'b0;
        end else begin
          s1_ff[g] <= stop_pins[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g]) pin_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate
  servo_sup_pkg::stop_pins_s pins;
  assign pins = pin_ff;

  // overrun detection
  logic signed [32:0] pos_diff;
  logic [32:0] diff_abs;
  logic [31:0] ovr_thr;
  logic ovr_hit;
  always_comb begin
    pos_diff = 33'(motor_pos) - 33'(scale_pos);
    diff_abs = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
    if (overrun_width_ff == 16'sd0) ovr_thr = servo_sup_pkg::OVR_DEFAULT_UM; // RQ3
    else if (function_select_five_ff[servo_sup_pkg::UNIT_UM_BIT]) ovr_thr = 32'(overrun_width_ff); // RQ4
    else ovr_thr = 32'(overrun_width_ff) * servo_sup_pkg::UM_PER_MM; // RQ4
    ovr_hit = ctrl_ff[servo_sup_pkg::CTRL_CLOSED] && overrun_width_ff != servo_sup_pkg::OVR_DISABLE
              && diff_abs > {1'b0, ovr_thr}; // RQ1 RQ2
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_alarm_ff <= 1'b0;
      axis_stop_ff <= 1'b0;
    end else begin
      if (ovr_hit) overrun_alarm_ff <= 1'b1; // RQ1
      else if (alm_rst_ff) overrun_alarm_ff <= 1'b0; // RQ24
      axis_stop_ff <= ovr_hit || (overrun_alarm_ff && !alm_rst_ff) || state_ff != servo_sup_pkg::ST_RUN; // RQ24
    end
  end

  // delay compensation and torque offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lead_reduce_ff <= 1'b0;
      delay_gain_out_ff <= 16'h0000;
      bad_sel_ff <= 1'b0;
      pullup_dir_ff <= 1'b0;
    end else begin
      bad_sel_ff <= servo_function_one_ff[1:0] == servo_sup_pkg::VC_BAD; // RQ5
      unique case (servo_function_one_ff[1:0])
        servo_sup_pkg::VC_TYPE1: begin
          lead_reduce_ff <= 1'b1; // RQ5
          delay_gain_out_ff <= delay_comp_gain_ff; // RQ7
        end
        servo_sup_pkg::VC_TYPE2: begin
          lead_reduce_ff <= pos_droop == 32'sd0; // RQ6
          delay_gain_out_ff <= delay_comp_gain_ff; // RQ7
        end
        default: begin
          lead_reduce_ff <= 1'b0; // RQ5
          delay_gain_out_ff <= 16'h0000;
        end
      endcase
      pullup_dir_ff <= torque_offset_ff[15]; // RQ8
    end
  end

  // millisecond tick and emergency stop sequencing
  logic [15:0] tick_cnt_ff, ms_cnt_ff;
  logic [31:0] budget_ff;
  wire tick = tick_cnt_ff == 16'(MS_CYCLES - 1);
  wire estop_cause = pins.estop || pins.power_down || pins.drive_alarm || overrun_alarm_ff; // RQ9
  wire tc_sync = estop_decel_time_const_ff[15];
  wire [15:0] tc_abs = tc_sync ? 16'(-estop_decel_time_const_ff) : estop_decel_time_const_ff;
  wire db_now = pins.db_alarm || (tc_sync && pins.sync_db); // RQ11 RQ14
  wire drop_on = ctrl_ff[servo_sup_pkg::CTRL_DROP];
  wire [15:0] gate_lim = (drop_on && drop_prevent_time_ff > max_gate_off_delay_ff) ?
                         drop_prevent_time_ff : max_gate_off_delay_ff; // RQ17
  wire gate_exp = ms_cnt_ff >= gate_lim; // RQ16
  wire drop_done = !drop_on || ms_cnt_ff >= drop_prevent_time_ff; // RQ22
  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt_ff <= 16'h0000;
    else tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= servo_sup_pkg::ST_RUN;
      ms_cnt_ff <= 16'h0000;
      budget_ff <= 32'h0000_0000;
      speed_out_ff <= 16'h0000;
      ready_ff <= 1'b0;
      dyn_brake_ff <= 1'b0;
      sync_db_out_ff <= 1'b0;
      pullup_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        servo_sup_pkg::ST_RUN: begin
          speed_out_ff <= speed_in;
          ready_ff <= 1'b1;
          dyn_brake_ff <= 1'b0;
          sync_db_out_ff <= 1'b0;
          pullup_ff <= 1'b0;
          ms_cnt_ff <= 16'h0000; // RQ23
          budget_ff <= 32'h0000_0000;
          if (estop_cause || db_now) begin
            if (db_now || !ctrl_ff[servo_sup_pkg::CTRL_DECEL]) begin
              state_ff <= servo_sup_pkg::ST_OFF; // RQ11
              ready_ff <= 1'b0;
              dyn_brake_ff <= 1'b1;
              speed_out_ff <= 16'h0000;
              sync_db_out_ff <= tc_sync; // RQ14
            end else begin
              state_ff <= servo_sup_pkg::ST_DECEL; // RQ10
              if (tc_abs == 16'h0000) speed_out_ff <= 16'h0000; // RQ13
              pullup_ff <= ctrl_ff[servo_sup_pkg::CTRL_PULLUP] && torque_offset_ff != 16'sd0; // RQ8
            end
          end
        end
        servo_sup_pkg::ST_DECEL: begin
          if (tick && ms_cnt_ff != 16'hFFFF) ms_cnt_ff <= ms_cnt_ff + 16'h0001; // RQ23
          if (tick) budget_ff <= budget_ff + 32'(rapid_ff); // RQ12
          else if (budget_ff >= 32'(tc_abs) && tc_abs != 16'h0000) begin
            budget_ff <= budget_ff - 32'(tc_abs); // RQ12
            if (speed_out_ff != 16'h0000) speed_out_ff <= speed_out_ff - 16'h0001;
          end
          if (drop_done) pullup_ff <= 1'b0;
          if (db_now) begin
            state_ff <= servo_sup_pkg::ST_OFF; // RQ11
            ready_ff <= 1'b0;
            dyn_brake_ff <= 1'b1;
            speed_out_ff <= 16'h0000;
            pullup_ff <= 1'b0;
            sync_db_out_ff <= tc_sync; // RQ14
          end else if (gate_exp || (speed_out_ff == 16'h0000 && drop_done)) begin
            state_ff <= servo_sup_pkg::ST_OFF; // RQ10 RQ16 RQ23
            ready_ff <= 1'b0;
            dyn_brake_ff <= 1'b1;
            pullup_ff <= 1'b0;
          end
        end
        servo_sup_pkg::ST_OFF: begin
          ready_ff <= 1'b0;
          dyn_brake_ff <= 1'b1;
          speed_out_ff <= 16'h0000;
          pullup_ff <= 1'b0;
          if (!estop_cause && !db_now) state_ff <= servo_sup_pkg::ST_RUN;
        end
        default: state_ff <= servo_sup_pkg::ST_OFF;
      endcase
    end
  end

  // machine end compensation by serial division
  logic [47:0] num_ff, quo_ff;
  logic [55:0] den_ff;
  logic [56:0] rem_ff;
  logic [5:0] step_ff;
  logic neg_ff, busy_ff;
  wire [56:0] rem_sh = {rem_ff[55:0], num_ff[47]};
  wire [14:0] gain_abs = machine_end_gain_ff[15] ? 15'(-machine_end_gain_ff) : machine_end_gain_ff[14:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      num_ff <= 48'h0;
      quo_ff <= 48'h0;
      den_ff <= 56'h0;
      rem_ff <= 57'h0;
      step_ff <= 6'h00;
      neg_ff <= 1'b0;
      busy_ff <= 1'b0;
      mec_amount_ff <= 32'sh0000_0000;
    end else if (!busy_ff) begin
      num_ff <= 48'(32'(speed_in) * 32'(speed_in)) * 48'(gain_abs); // RQ20
      den_ff <= 56'(radius_ff) * 56'(position_loop_gain_ff) * 56'(servo_sup_pkg::MEC_SCALE); // RQ20
      neg_ff <= machine_end_gain_ff[15];
      rem_ff <= 57'h0;
      step_ff <= 6'h00;
      busy_ff <= 1'b1;
    end else begin
      num_ff <= {num_ff[46:0], 1'b0};
      if (rem_sh >= {1'b0, den_ff}) begin
        rem_ff <= rem_sh - {1'b0, den_ff};
        quo_ff <= {quo_ff[46:0], 1'b1};
      end else begin
        rem_ff <= rem_sh;
        quo_ff <= {quo_ff[46:0], 1'b0};
      end
      step_ff <= step_ff + 6'h01;
      if (step_ff == 6'(servo_sup_pkg::DIV_STEPS)) begin
        busy_ff <= 1'b0;
        if (den_ff == 56'h0 || machine_end_gain_ff == 16'sd0) mec_amount_ff <= 32'sh0000_0000; // RQ19
        else mec_amount_ff <= neg_ff ? -32'(quo_ff[31:0]) : 32'(quo_ff[31:0]); // RQ20
      end
    end
  end

  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ovr_seen;
    ovr_hit;
  endsequence
  overrun_latch_a: assert property (ovr_seen |=> overrun_alarm_ff) else $error("overrun not latched"); // RQ1
  overrun_hold_a: assert property (overrun_alarm_ff && !alm_rst_ff |=> overrun_alarm_ff) // RQ24
    else $error("overrun alarm dropped");
  overrun_off_a: assert property (overrun_width_ff == servo_sup_pkg::OVR_DISABLE && !overrun_alarm_ff // RQ2
    |=> !overrun_alarm_ff) else $error("overrun raised while disabled");
  default_width_a: assert property (overrun_width_ff == 16'sd0 && ctrl_ff[0] // RQ3
    && diff_abs > 33'd2000 |-> ovr_hit) else $error("default width not applied");
  type2_droop_a: assert property (servo_function_one_ff[1:0] == 2'b10 && pos_droop != 32'sd0 ##1 // RQ6
    servo_function_one_ff[1:0] == 2'b10 |-> !lead_reduce_ff) else $error("lead reduced with droop");
  prohibited_sel_a: assert property (servo_function_one_ff[1:0] == 2'b11 |=> delay_gain_out_ff == 16'h0000) // RQ5
    else $error("prohibited selector applied gain");
  sequence db_stop;
    state_ff != servo_sup_pkg::ST_OFF && db_now;
  endsequence
  db_immediate_a: assert property (db_stop |=> dyn_brake_ff && !ready_ff && speed_out_ff == 16'h0000) // RQ11
    else $error("dynamic brake not immediate");
  decel_ready_a: assert property (state_ff == servo_sup_pkg::ST_DECEL |-> ready_ff) // RQ10
    else $error("ready dropped during ramp");
  gate_force_a: assert property (state_ff == servo_sup_pkg::ST_DECEL && gate_exp |=> !ready_ff) // RQ16
    else $error("gate-off delay not enforced");
  drop_hold_a: assert property (state_ff == servo_sup_pkg::ST_DECEL && drop_on && !drop_done && !db_now // RQ17
    |=> ready_ff) else $error("ready off before drop time");
  sync_prop_a: assert property (state_ff == servo_sup_pkg::ST_DECEL && tc_sync && pins.sync_db // RQ14
    |=> sync_db_out_ff ##1 dyn_brake_ff) else $error("sync brake not propagated");
  step_stop_a: assert property (state_ff == servo_sup_pkg::ST_RUN && estop_cause && !db_now && ctrl_ff[1] // RQ13
    && tc_abs == 16'h0000 |=> speed_out_ff == 16'h0000) else $error("zero constant did not step");
endmodule : servo_estop_overrun_supervisor

// ### tb/nc_model.sv
// controller model: stop causes, speed command, feedback
`timescale 1ns/1ps
module nc_model (
  // bench side
  input wire logic aclk,
  input wire logic [4:0] cause,
  input wire logic [31:0] gap,
  // drive side
  output servo_sup_pkg::stop_pins_s stop_pins = '0,
  output logic [15:0] speed_in = '0,
  output logic signed [31:0] motor_pos = '0,
  output logic signed [31:0] scale_pos = '0,
  output logic signed [31:0] pos_droop = '0
);
  always @(posedge aclk) begin
    stop_pins <= cause;
    speed_in <= 16'h8000 | 16'($urandom);
    motor_pos <= 32'sh0001_0000;
    scale_pos <= 32'sh0001_0000 - gap;
    pos_droop <= 32'($urandom_range(0, 3));
  end
endmodule : nc_model

// ### tb/testbench.sv
// self-checking bench of the servo supervisor
`timescale 1ns/1ps
module testbench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ready_ff;
  logic dyn_brake_ff, axis_stop_ff, overrun_alarm_ff, sync_db_out_ff, lead_reduce_ff, pullup_ff, pullup_dir_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [4:0] cause = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [15:0] speed_in, speed_out_ff, delay_gain_out_ff;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, gap = 0;
  logic signed [31:0] motor_pos, scale_pos, pos_droop, mec_amount_ff;
  servo_sup_pkg::stop_pins_s stop_pins;
  logic [7:0] ad [6] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
  logic [31:0] wv [6] = '{32'hFFFF_FFFB, 32'h0000_9C40, 32'hFFFF_FF38, 32'hFFFF_8AD0, 32'h0000_7530, 32'h0001_869F};
  logic [31:0] ex [6] = '{32'hFFFF_FFFF, 32'h0000_7FFF, 32'hFFFF_FF9C, 32'hFFFF_B1E0, 32'h0000_4E20, 32'h0000_7530};
  int n_fail = 0, compares = 0;
  servo_estop_overrun_supervisor #(.MS_CYCLES(20)) u_dut (.*);
  nc_model u_nc (.*);
  initial forever #25 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    {rv, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
  endtask : rd
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    #1ms;
    n_fail++;
    complete_run();
  end
  initial begin
    void'($urandom(23));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(8'h34);
    chk({rv[15:8], rv[1]}, 9'h057);
    rd(8'h3C);
    chk(rr, 2'h3);
    for (int i = 0; i < 6; i++) begin
      wr(ad[i], wv[i]);
      rd(ad[i]);
      chk(rv, ex[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, 32'(i));
      rd(8'h34);
      chk({delay_gain_out_ff, rv[6]}, {(i == 1 || i == 2) ? 16'h7FFF : 16'h0000, i == 3});
      if (i != 2) chk(lead_reduce_ff, 32'(i == 1));
    end
    $display("register test done");
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0000_0000);
    gap <= 32'h0000_07D0;
    repeat (8) @(posedge aclk);
    chk(overrun_alarm_ff, 1'h0);
    gap <= 32'h0000_07D1 + $urandom_range(0, 999);
    repeat (8) @(posedge aclk);
    chk({overrun_alarm_ff, axis_stop_ff, ready_ff}, 3'h6);
    gap <= 0;
    repeat (8) @(posedge aclk);
    chk(overrun_alarm_ff, 1'h1);
    wr(8'h00, 32'h0000_0009);
    repeat (10) @(posedge aclk);
    chk({overrun_alarm_ff, ready_ff}, 2'h1);
    wr(8'h04, 32'hFFFF_FFFF);
    gap <= 32'h0100_0000 + $urandom_range(0, 9999);
    repeat (8) @(posedge aclk);
    chk(overrun_alarm_ff, 1'h0);
    gap <= 0;
    $display("overrun test done");
    rd(8'h38);
    chk(32'(rv >= 32'h001E_573A && rv <= 32'h0079_5BF8), 32'h0000_0001);
    wr(8'h20, 32'h0000_0000);
    repeat (60) @(posedge aclk);
    chk(mec_amount_ff, 32'h0000_0000);
    wr(8'h30, 32'h0000_0001);
    wr(8'h14, 32'h0000_0001);
    wr(8'h18, 32'h0000_0065);
    wr(8'h00, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      cause <= 5'(1 << i);
      repeat (12) @(posedge aclk);
      chk({ready_ff, dyn_brake_ff}, {i != 3, i == 3});
      repeat (2100) @(posedge aclk);
      chk({ready_ff, dyn_brake_ff}, 2'h1);
      cause <= 0;
      repeat (12) @(posedge aclk);
      chk({ready_ff, speed_out_ff[15]}, 2'h3);
    end
    wr(8'h14, 32'hFFFF_FFFF);
    cause <= 5'h01;
    repeat (12) @(posedge aclk);
    cause <= 5'h11;
    repeat (12) @(posedge aclk);
    chk({ready_ff, dyn_brake_ff, sync_db_out_ff}, 3'h3);
    cause <= 0;
    wr(8'h14, 32'h0000_0000);
    cause <= 5'h01;
    repeat (12) @(posedge aclk);
    chk({speed_out_ff, ready_ff, dyn_brake_ff}, 18'h0_0001);
    cause <= 0;
    repeat (12) @(posedge aclk);
    wr(8'h1C, 32'h0000_0078);
    wr(8'h00, 32'h0000_0016);
    cause <= 5'h01;
    repeat (2200) @(posedge aclk);
    chk({ready_ff, pullup_ff, pullup_dir_ff}, 3'h7);
    repeat (300) @(posedge aclk);
    chk({ready_ff, dyn_brake_ff}, 2'h1);
    cause <= 0;
    $display("stop test done");
    complete_run();
  end
endmodule : testbench
